// ===== hdl/lts_pkg.sv
// Shared constants and types for the layered trigger sequencer.
package lts_pkg;
    typedef enum logic [2:0] {
        LTS_SRC_IMM = 3'h0,
        LTS_SRC_EXT = 3'h1,
        LTS_SRC_MAN = 3'h2,
        LTS_SRC_BUS = 3'h3,
        LTS_SRC_LINK = 3'h4,
        LTS_SRC_TIMER = 3'h5,
        LTS_SRC_HOLD = 3'h6
    } lts_src_e;

    // Gray codes along idle, arm, scan, measure, read, open, configure, close.
    typedef enum logic [3:0] {
        LTS_ST_IDLE = 4'h0,
        LTS_ST_ARM = 4'h1,
        LTS_ST_SCAN = 4'h3,
        LTS_ST_MEAS = 4'h2,
        LTS_ST_READ = 4'h6,
        LTS_ST_OPEN = 4'h7,
        LTS_ST_CFG = 4'h5,
        LTS_ST_CLOSE = 4'h4
    } lts_state_e;

    localparam int LTS_CNT_W = 17;
    localparam int LTS_TMR_W = 40;
    localparam logic [16:0] LTS_CNT_MIN = 17'h00001;
    localparam logic [16:0] LTS_CNT_MAX = 17'h1869F;

    typedef struct packed {
        lts_src_e src;
        logic inf;
        logic [LTS_CNT_W-1:0] count;
    } lts_layer_cfg_s;

    localparam lts_layer_cfg_s LTS_ARM_CFG_RST = '{LTS_SRC_IMM, 1'b0, 17'h00001};
    localparam lts_layer_cfg_s LTS_SCAN_CFG_RST = '{LTS_SRC_IMM, 1'b1, 17'h00001};
    localparam lts_layer_cfg_s LTS_MEAS_CFG_RST = '{LTS_SRC_IMM, 1'b1, 17'h00001};
    localparam logic [39:0] LTS_INT_RST = 40'h00_0000_0001;

    localparam logic [7:0] LTS_OFF_CTRL = 8'h00;
    localparam logic [7:0] LTS_OFF_STATUS = 8'h04;
    localparam logic [7:0] LTS_OFF_ARM_CFG = 8'h08;
    localparam logic [7:0] LTS_OFF_SCAN_CFG = 8'h0C;
    localparam logic [7:0] LTS_OFF_MEAS_CFG = 8'h10;
    localparam logic [7:0] LTS_OFF_SCAN_INT_LO = 8'h14;
    localparam logic [7:0] LTS_OFF_SCAN_INT_HI = 8'h18;
    localparam logic [7:0] LTS_OFF_MEAS_INT_LO = 8'h1C;
    localparam logic [7:0] LTS_OFF_MEAS_INT_HI = 8'h20;
    localparam logic [7:0] LTS_OFF_CMD = 8'h24;

    localparam int LTS_CTRL_START = 0;
    localparam int LTS_CTRL_ABORT = 1;
    localparam int LTS_CTRL_SCAN_EN = 2;
    localparam int LTS_STAT_ARMED = 4;
    localparam int LTS_STAT_IGN = 5;
    localparam int LTS_CMD_SIGNAL = 0;
    localparam int LTS_CMD_IMMEDIATE = 1;
    localparam int LTS_CFG_SRC_LSB = 0;
    localparam int LTS_CFG_INF = 3;
    localparam int LTS_CFG_CNT_LSB = 8;

    localparam int LTS_CLK_PERIOD_NS = 4;
    localparam int LTS_MS_NS = 1000000;
    localparam int LTS_CYC_PER_MS = (LTS_MS_NS + LTS_CLK_PERIOD_NS - 1) / LTS_CLK_PERIOD_NS;
    localparam int LTS_PRE_W = 18;
endpackage : lts_pkg

// ===== hdl/lts_event_if.sv
// Event pulses shared by the sequencer and its layer gates.
`timescale 1ns/1ps
interface lts_event_if;
    logic ext;
    logic man;
    logic bus;
    logic link;
    logic lay_sig;
    logic lay_imm;
    modport src (output ext, output man, output bus, output link, output lay_sig, output lay_imm);
    modport gate (input ext, input man, input bus, input link, input lay_sig, input lay_imm);
endinterface : lts_event_if

// ===== hdl/lts_layer_gate.sv
// Event detector for one layer of the sequencer.
`timescale 1ns/1ps
module lts_layer_gate
    import lts_pkg::*;
#(
    parameter bit HAS_TIMER = 1'b1,
    parameter bit HAS_CMD = 1'b0
) (
    input wire logic waiting,
    input wire logic active,
    input wire lts_src_e src,
    lts_event_if.gate ev,
    input wire logic timer_ok,
    output logic fire,
    output logic ignored
);
    always_comb begin
        fire = 1'b0;
        case (src)
            LTS_SRC_IMM: fire = 1'b1;
            LTS_SRC_EXT: fire = ev.ext;
            LTS_SRC_MAN: fire = ev.man;
            LTS_SRC_BUS: fire = ev.bus;
            LTS_SRC_LINK: fire = ev.link;
            LTS_SRC_TIMER: fire = HAS_TIMER & timer_ok;
            default: fire = 1'b0;
        endcase
        // Hold releases only through a source change or a layer command.
        if (HAS_CMD && (ev.lay_sig || ev.lay_imm)) begin
            fire = 1'b1;
        end
        fire = fire & waiting;
        ignored = active && (src == LTS_SRC_IMM) && (ev.ext || ev.man);
    end
endmodule : lts_layer_gate

// ===== hdl/lts_interval_timer.sv
// Millisecond interval timer for the scan and measure layers.
`timescale 1ns/1ps
module lts_interval_timer
    import lts_pkg::*;
#(
    parameter int CYC_PER_MS = LTS_CYC_PER_MS
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic restart,
    input wire logic [LTS_TMR_W-1:0] interval,
    output logic expired
);
    typedef struct packed {
        logic [LTS_PRE_W-1:0] pre;
        logic [LTS_TMR_W-1:0] ms;
        logic expired;
    } lts_tmr_s;

    lts_tmr_s r;
    lts_tmr_s next_r;

    always_comb begin
        next_r = r;
        if (restart) begin
            next_r = '0;
        end else if (!r.expired) begin
            next_r.pre = r.pre + 18'h00001;
            if (r.pre == LTS_PRE_W'(CYC_PER_MS - 1)) begin
                next_r.pre = '0;
                next_r.ms = r.ms + 40'h00_0000_0001;
                // A zero interval behaves as the shortest, one millisecond.
                if (r.ms + 40'h00_0000_0001 >= interval) begin
                    next_r.expired = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign expired = r.expired;
endmodule : lts_interval_timer

// ===== hdl/lts_sequencer.sv
// Arm, scan and measure trigger sequencer with its APB register file.
`timescale 1ns/1ps
module lts_sequencer
    import lts_pkg::*;
#(
    parameter int CYC_PER_MS = LTS_CYC_PER_MS
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_trigger_in,
    input wire logic manual_trigger_key,
    input wire logic bus_trigger,
    input wire logic link_trigger_in,
    input wire logic reading_done,
    output logic armed,
    output logic reading_req,
    output logic channel_open,
    output logic config_next,
    output logic channel_close,
    output logic trigger_ignored
);
    typedef struct packed {
        lts_state_e state;
        logic armed;
        logic [LTS_CNT_W-1:0] arm_cnt;
        logic [LTS_CNT_W-1:0] scan_cnt;
        logic [LTS_CNT_W-1:0] meas_cnt;
        logic scan_first;
        logic meas_first;
        lts_layer_cfg_s arm_cfg;
        lts_layer_cfg_s scan_cfg;
        lts_layer_cfg_s meas_cfg;
        logic scan_en;
        logic [LTS_TMR_W-1:0] scan_int;
        logic [LTS_TMR_W-1:0] meas_int;
        logic ign_sticky;
        logic [31:0] prdata;
        logic reading_req;
        logic channel_open;
        logic config_next;
        logic channel_close;
        logic trigger_ignored;
    } lts_seq_s;

    localparam lts_seq_s LTS_SEQ_RST = '{
        state: LTS_ST_IDLE,
        arm_cfg: LTS_ARM_CFG_RST,
        scan_cfg: LTS_SCAN_CFG_RST,
        meas_cfg: LTS_MEAS_CFG_RST,
        scan_int: LTS_INT_RST,
        meas_int: LTS_INT_RST,
        default: '0
    };

    lts_seq_s r;
    lts_seq_s next_r;

    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic start_req;
    logic abort_req;
    logic arm_fire;
    logic scan_fire;
    logic meas_fire;
    logic arm_ign;
    logic scan_ign;
    logic meas_ign;
    logic scan_tmr_exp;
    logic meas_tmr_exp;
    logic in_arm;
    logic in_scan;
    logic in_meas;
    logic act_done;
    logic [31:0] rd_word;

    lts_event_if ev ();

    assign ev.ext = ext_trigger_in;
    assign ev.man = manual_trigger_key;
    assign ev.bus = bus_trigger;
    assign ev.link = link_trigger_in;
    assign ev.lay_sig = wr_en && (paddr == LTS_OFF_CMD) && pwdata[LTS_CMD_SIGNAL];
    assign ev.lay_imm = wr_en && (paddr == LTS_OFF_CMD) && pwdata[LTS_CMD_IMMEDIATE];

    // Registers answer with no wait state; read data is caught in the setup cycle.
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped = (paddr <= LTS_OFF_CMD) && (paddr[1:0] == 2'h0);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = r.prdata;

    assign start_req = (r.state == LTS_ST_IDLE)
        && ((wr_en && (paddr == LTS_OFF_CTRL) && pwdata[LTS_CTRL_START]) || manual_trigger_key);
    assign abort_req = wr_en && (paddr == LTS_OFF_CTRL) && pwdata[LTS_CTRL_ABORT];

    assign in_arm = (r.state != LTS_ST_IDLE);
    assign in_scan = in_arm && (r.state != LTS_ST_ARM);
    assign in_meas = in_scan && (r.state != LTS_ST_SCAN);

    lts_layer_gate #(.HAS_TIMER(1'b0), .HAS_CMD(1'b1)) u_arm_gate (
        .waiting(r.state == LTS_ST_ARM),
        .active(in_arm),
        .src(r.arm_cfg.src),
        .ev(ev),
        .timer_ok(1'b0),
        .fire(arm_fire),
        .ignored(arm_ign)
    );

    lts_layer_gate #(.HAS_TIMER(1'b1), .HAS_CMD(1'b0)) u_scan_gate (
        .waiting(r.state == LTS_ST_SCAN),
        .active(in_scan),
        .src(r.scan_cfg.src),
        .ev(ev),
        .timer_ok(r.scan_first || scan_tmr_exp),
        .fire(scan_fire),
        .ignored(scan_ign)
    );

    lts_layer_gate #(.HAS_TIMER(1'b1), .HAS_CMD(1'b0)) u_meas_gate (
        .waiting(r.state == LTS_ST_MEAS),
        .active(in_meas),
        .src(r.meas_cfg.src),
        .ev(ev),
        .timer_ok(r.meas_first || meas_tmr_exp),
        .fire(meas_fire),
        .ignored(meas_ign)
    );

    // Each pass restarts the timer, so the interval runs from the previous pass.
    lts_interval_timer #(.CYC_PER_MS(CYC_PER_MS)) u_scan_timer (
        .clock(clock),
        .arst_n(arst_n),
        .restart(scan_fire),
        .interval(r.scan_int),
        .expired(scan_tmr_exp)
    );

    lts_interval_timer #(.CYC_PER_MS(CYC_PER_MS)) u_meas_timer (
        .clock(clock),
        .arst_n(arst_n),
        .restart(meas_fire),
        .interval(r.meas_int),
        .expired(meas_tmr_exp)
    );

    // Counts outside the legal range are clamped rather than rejected.
    function automatic lts_layer_cfg_s cfg_from_word(input logic [31:0] w);
        lts_layer_cfg_s c;
        c.src = lts_src_e'(w[LTS_CFG_SRC_LSB +: 3]);
        c.inf = w[LTS_CFG_INF];
        c.count = w[LTS_CFG_CNT_LSB +: LTS_CNT_W];
        if (c.count < LTS_CNT_MIN) begin
            c.count = LTS_CNT_MIN;
        end else if (c.count > LTS_CNT_MAX) begin
            c.count = LTS_CNT_MAX;
        end
        return c;
    endfunction : cfg_from_word

    function automatic logic [31:0] cfg_to_word(input lts_layer_cfg_s c);
        logic [31:0] w;
        w = '0;
        w[LTS_CFG_SRC_LSB +: 3] = c.src;
        w[LTS_CFG_INF] = c.inf;
        w[LTS_CFG_CNT_LSB +: LTS_CNT_W] = c.count;
        return w;
    endfunction : cfg_to_word

    always_comb begin
        rd_word = '0;
        if (paddr == LTS_OFF_CTRL) begin
            rd_word[LTS_CTRL_SCAN_EN] = r.scan_en;
        end else if (paddr == LTS_OFF_STATUS) begin
            rd_word[3:0] = r.state;
            rd_word[LTS_STAT_ARMED] = r.armed;
            rd_word[LTS_STAT_IGN] = r.ign_sticky;
        end else if (paddr == LTS_OFF_ARM_CFG) begin
            rd_word = cfg_to_word(r.arm_cfg);
        end else if (paddr == LTS_OFF_SCAN_CFG) begin
            rd_word = cfg_to_word(r.scan_cfg);
        end else if (paddr == LTS_OFF_MEAS_CFG) begin
            rd_word = cfg_to_word(r.meas_cfg);
        end else if (paddr == LTS_OFF_SCAN_INT_LO) begin
            rd_word = r.scan_int[31:0];
        end else if (paddr == LTS_OFF_SCAN_INT_HI) begin
            rd_word[7:0] = r.scan_int[39:32];
        end else if (paddr == LTS_OFF_MEAS_INT_LO) begin
            rd_word = r.meas_int[31:0];
        end else if (paddr == LTS_OFF_MEAS_INT_HI) begin
            rd_word[7:0] = r.meas_int[39:32];
        end
    end

    always_comb begin
        next_r = r;
        act_done = 1'b0;
        next_r.reading_req = 1'b0;
        next_r.channel_open = 1'b0;
        next_r.config_next = 1'b0;
        next_r.channel_close = 1'b0;
        next_r.trigger_ignored = 1'b0;
        if (rd_setup) begin
            next_r.prdata = rd_word;
        end
        if (wr_en) begin
            if (paddr == LTS_OFF_CTRL) begin
                next_r.scan_en = pwdata[LTS_CTRL_SCAN_EN];
            end else if (paddr == LTS_OFF_STATUS) begin
                if (pwdata[LTS_STAT_IGN]) begin
                    next_r.ign_sticky = 1'b0;
                end
            end else if (paddr == LTS_OFF_ARM_CFG) begin
                next_r.arm_cfg = cfg_from_word(pwdata);
            end else if (paddr == LTS_OFF_SCAN_CFG) begin
                next_r.scan_cfg = cfg_from_word(pwdata);
            end else if (paddr == LTS_OFF_MEAS_CFG) begin
                next_r.meas_cfg = cfg_from_word(pwdata);
            end else if (paddr == LTS_OFF_SCAN_INT_LO) begin
                next_r.scan_int[31:0] = pwdata;
            end else if (paddr == LTS_OFF_SCAN_INT_HI) begin
                next_r.scan_int[39:32] = pwdata[7:0];
            end else if (paddr == LTS_OFF_MEAS_INT_LO) begin
                next_r.meas_int[31:0] = pwdata;
            end else if (paddr == LTS_OFF_MEAS_INT_HI) begin
                next_r.meas_int[39:32] = pwdata[7:0];
            end
        end
        // A fresh ignored trigger wins over a clear in the same cycle.
        if (arm_ign || scan_ign || meas_ign) begin
            next_r.trigger_ignored = 1'b1;
            next_r.ign_sticky = 1'b1;
        end
        case (r.state)
            LTS_ST_IDLE: begin
                if (start_req) begin
                    next_r.state = LTS_ST_ARM;
                    next_r.armed = 1'b1;
                    next_r.arm_cnt = '0;
                end
            end
            LTS_ST_ARM: begin
                if (arm_fire) begin
                    next_r.state = LTS_ST_SCAN;
                    next_r.arm_cnt = r.arm_cnt + 17'h00001;
                    next_r.scan_cnt = '0;
                    next_r.scan_first = 1'b1;
                end
            end
            LTS_ST_SCAN: begin
                if (scan_fire) begin
                    next_r.state = LTS_ST_MEAS;
                    next_r.scan_cnt = r.scan_cnt + 17'h00001;
                    next_r.scan_first = 1'b0;
                    next_r.meas_cnt = '0;
                    next_r.meas_first = 1'b1;
                end
            end
            LTS_ST_MEAS: begin
                if (meas_fire) begin
                    next_r.state = LTS_ST_READ;
                    next_r.reading_req = 1'b1;
                    next_r.meas_first = 1'b0;
                end
            end
            LTS_ST_READ: begin
                if (reading_done) begin
                    if (r.scan_en) begin
                        next_r.state = LTS_ST_OPEN;
                        next_r.channel_open = 1'b1;
                    end else begin
                        act_done = 1'b1;
                    end
                end
            end
            LTS_ST_OPEN: begin
                next_r.state = LTS_ST_CFG;
                next_r.config_next = 1'b1;
            end
            LTS_ST_CFG: begin
                next_r.state = LTS_ST_CLOSE;
                next_r.channel_close = 1'b1;
            end
            LTS_ST_CLOSE: begin
                act_done = 1'b1;
            end
            default: begin
                next_r.state = LTS_ST_IDLE;
            end
        endcase
        if (act_done) begin
            next_r.state = LTS_ST_MEAS;
            next_r.meas_cnt = r.meas_cnt + 17'h00001;
            if (!r.meas_cfg.inf && (r.meas_cnt + 17'h00001 >= r.meas_cfg.count)) begin
                next_r.state = LTS_ST_SCAN;
                if (!r.scan_cfg.inf && (r.scan_cnt >= r.scan_cfg.count)) begin
                    next_r.state = LTS_ST_ARM;
                    if (!r.arm_cfg.inf && (r.arm_cnt >= r.arm_cfg.count)) begin
                        next_r.state = LTS_ST_IDLE;
                        next_r.armed = 1'b0;
                    end
                end
            end
        end
        // Abort drops back to idle from any layer and disarms.
        if (abort_req) begin
            next_r.state = LTS_ST_IDLE;
            next_r.armed = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r <= LTS_SEQ_RST;
        end else begin
            r <= next_r;
        end
    end

    assign armed = r.armed;
    assign reading_req = r.reading_req;
    assign channel_open = r.channel_open;
    assign config_next = r.config_next;
    assign channel_close = r.channel_close;
    assign trigger_ignored = r.trigger_ignored;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    chk_idle_disarmed: assert property ((r.state == LTS_ST_IDLE) |-> !armed)
        else $error("armed while idle");
    chk_start_arms: assert property (start_req && !abort_req |=> armed && (r.state == LTS_ST_ARM))
        else $error("start did not arm");
    chk_arm_immediate: assert property ((r.state == LTS_ST_ARM) && (r.arm_cfg.src == LTS_SRC_IMM) && !abort_req
        |=> (r.state == LTS_ST_SCAN))
        else $error("immediate arm did not pass to scan");
    chk_ext_waits: assert property ((r.state == LTS_ST_ARM) && (r.arm_cfg.src == LTS_SRC_EXT) && !ext_trigger_in
        && !ev.lay_sig && !ev.lay_imm && !abort_req |=> (r.state == LTS_ST_ARM) && !reading_req)
        else $error("arm layer left without external trigger");
    chk_manual_release: assert property ((r.state == LTS_ST_ARM) && (r.arm_cfg.src == LTS_SRC_MAN)
        && manual_trigger_key && !abort_req |=> (r.state == LTS_ST_SCAN))
        else $error("manual key did not release arm");
    chk_hold_command: assert property ((r.state == LTS_ST_ARM) && (r.arm_cfg.src == LTS_SRC_HOLD)
        && (ev.lay_sig || ev.lay_imm) && !abort_req |=> (r.state == LTS_ST_SCAN))
        else $error("layer command did not release hold");
    chk_ignored_flag: assert property ((r.state != LTS_ST_IDLE) && (r.arm_cfg.src == LTS_SRC_IMM) && ext_trigger_in
        |=> trigger_ignored && r.ign_sticky)
        else $error("ignored trigger not flagged");
    chk_scan_to_meas: assert property ((r.state == LTS_ST_SCAN) ##1 (r.state != LTS_ST_SCAN) && !$past(abort_req)
        |-> (r.state == LTS_ST_MEAS))
        else $error("scan layer left to wrong layer");
    chk_meas_immediate: assert property ((r.state == LTS_ST_MEAS) && (r.meas_cfg.src == LTS_SRC_IMM) && !abort_req
        |=> reading_req)
        else $error("immediate measure did not request reading");
    chk_scan_order: assert property ((r.state == LTS_ST_READ) && reading_done && r.scan_en && !abort_req
        |=> channel_open ##1 config_next ##1 channel_close)
        else $error("scan action out of order");
    chk_meas_exhaust: assert property ((r.state == LTS_ST_CLOSE) && !abort_req && !r.meas_cfg.inf
        && (r.meas_cnt + 17'h00001 < r.meas_cfg.count) |=> (r.state == LTS_ST_MEAS))
        else $error("measure count not honoured");
endmodule : lts_sequencer

// ===== tb/lts_manual_trigger_key_model.sv
// Model of the trigger sources: rear input, front key, bus controller and link.
`timescale 1ns/1ps
module lts_manual_trigger_key_model
    import lts_pkg::*;
(
    input wire logic clock,
    input wire logic go,
    input wire lts_src_e kind,
    output logic ext_trigger_in,
    output logic manual_trigger_key,
    output logic bus_trigger,
    output logic link_trigger_in
);
    initial {ext_trigger_in, manual_trigger_key, bus_trigger, link_trigger_in} = 4'h0;
    // Each source gives a single clean pulse, because a held level would fire a layer again.
    always @(posedge clock) begin
        ext_trigger_in <= go && kind == LTS_SRC_EXT;
        manual_trigger_key <= go && kind == LTS_SRC_MAN;
        bus_trigger <= go && kind == LTS_SRC_BUS;
        link_trigger_in <= go && kind == LTS_SRC_LINK;
    end
endmodule : lts_manual_trigger_key_model

// ===== tb/tb.sv
// Self-checking bench for the layered trigger sequencer.
`timescale 1ns/1ps
module tb;
    import lts_pkg::*;
    localparam int TB_CPM = 4;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ext, man, bus, link, e;
    logic armed, reading_req, channel_open, config_next, channel_close, trigger_ignored;
    logic go = 1'b0;
    logic done = 1'b1;
    lts_src_e kind = LTS_SRC_IMM;
    logic [31:0] q;
    int errors = 0, comparisons = 0, n_rd = 0, cyc = 0, last = 0, gap = 0;
    always #2 clock = ~clock;
    lts_manual_trigger_key_model lts_manual_trigger_key_model_i (.clock(clock), .go(go), .kind(kind), .ext_trigger_in(ext),
        .manual_trigger_key(man), .bus_trigger(bus), .link_trigger_in(link));
    lts_sequencer #(.CYC_PER_MS(TB_CPM)) lts_sequencer_i (.clock(clock), .arst_n(arst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trigger_in(ext),
        .manual_trigger_key(man), .bus_trigger(bus), .link_trigger_in(link), .reading_done(done),
        .armed(armed), .reading_req(reading_req), .channel_open(channel_open),
        .config_next(config_next), .channel_close(channel_close), .trigger_ignored(trigger_ignored));
    // Counted at the falling edge, where registered outputs have settled.
    always @(negedge clock) begin
        cyc++;
        if (reading_req === 1'b1) begin
            gap = cyc - last;
            last = cyc;
            n_rd++;
        end
    end
    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        // One idle cycle keeps the next setup from landing in the release time step.
        @(posedge clock);
    endtask : apb
    task automatic await(ref logic s, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (s !== v && n < 3000);
        if (n >= 3000) begin
            errors++;
            give_verdict();
        end
    endtask : await
    task automatic fire(input lts_src_e k);
        kind <= k;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask : fire
    task automatic start_and_finish();
        n_rd = 0;
        apb(1'b1, LTS_OFF_CTRL, 32'h1);
        await(armed, 1'b0);
        @(posedge clock);
    endtask : start_and_finish
    task automatic run(input logic [31:0] acfg, input lts_src_e k, input logic [1:0] cmd);
        apb(1'b1, LTS_OFF_ARM_CFG, acfg);
        n_rd = 0;
        apb(1'b1, LTS_OFF_CTRL, 32'h1);
        apb(1'b0, LTS_OFF_STATUS, 32'h0);
        chk("arm wait", q[4:0], 32'h11);
        fire(k);
        if (cmd != 2'b00) apb(1'b1, LTS_OFF_CMD, {30'h0, cmd});
        await(armed, 1'b0);
        @(posedge clock);
        chk("readings", n_rd, 32'h2);
    endtask : run
    initial begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, LTS_OFF_STATUS, 32'h0);
        chk("status", q, 32'h0);
        apb(1'b0, LTS_OFF_ARM_CFG, 32'h0);
        chk("arm cfg", q, 32'h100);
        apb(1'b0, LTS_OFF_SCAN_CFG, 32'h0);
        chk("scan cfg", q, 32'h108);
        apb(1'b0, LTS_OFF_MEAS_CFG, 32'h0);
        chk("meas cfg", q, 32'h108);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped", {e, q[30:0]}, 32'h80000000);
        apb(1'b1, LTS_OFF_MEAS_CFG, 32'h186A0 << 8);
        apb(1'b0, LTS_OFF_MEAS_CFG, 32'h0);
        chk("count max", q, 32'h1869F00);
        apb(1'b1, LTS_OFF_SCAN_CFG, 32'h0);
        apb(1'b0, LTS_OFF_SCAN_CFG, 32'h0);
        chk("count min", q, 32'h100);
        apb(1'b1, LTS_OFF_MEAS_CFG, 32'h200);
        apb(1'b1, LTS_OFF_ARM_CFG, 32'h200);
        start_and_finish();
        chk("two arms", n_rd, 32'h4);
        for (int k = 1; k <= 4; k++) run(32'h100 | k, lts_src_e'(k), 2'b00);
        run(32'h106, LTS_SRC_HOLD, 2'b01);
        run(32'h106, LTS_SRC_HOLD, 2'b10);
        apb(1'b1, LTS_OFF_ARM_CFG, 32'h100);
        apb(1'b1, LTS_OFF_MEAS_CFG, 32'h200);
        n_rd = 0;
        done <= 1'b0;
        apb(1'b1, LTS_OFF_CTRL, 32'h5);
        // The first reading is held back, so channel switching must wait for it.
        await(reading_req, 1'b1);
        @(negedge clock);
        chk("open waits", channel_open, 32'h0);
        @(posedge clock);
        done <= 1'b1;
        await(channel_open, 1'b1);
        chk("read first", n_rd, 32'h1);
        @(negedge clock);
        chk("config", config_next, 32'h1);
        @(negedge clock);
        chk("close", channel_close, 32'h1);
        await(armed, 1'b0);
        @(posedge clock);
        chk("scan reads", n_rd, 32'h2);
        apb(1'b1, LTS_OFF_CTRL, 32'h0);
        // The timer layer is run with a count of two, so the second pass must wait an interval.
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, LTS_OFF_SCAN_CFG, i ? 32'h205 : 32'h100);
            apb(1'b1, LTS_OFF_MEAS_CFG, i ? 32'h100 : 32'h205);
            start_and_finish();
            chk("timer reads", n_rd, 32'h2);
            chk("timer gap", gap >= TB_CPM, 32'h1);
        end
        apb(1'b1, LTS_OFF_MEAS_CFG, 32'h008);
        apb(1'b1, LTS_OFF_CTRL, 32'h1);
        for (int k = 1; k <= 2; k++) begin
            fire(lts_src_e'(k));
            await(trigger_ignored, 1'b1);
            @(posedge clock);
        end
        apb(1'b0, LTS_OFF_STATUS, 32'h0);
        chk("ignored flag", q[5], 32'h1);
        apb(1'b1, LTS_OFF_STATUS, 32'h20);
        apb(1'b0, LTS_OFF_STATUS, 32'h0);
        chk("ignored clear", q[5], 32'h0);
        apb(1'b1, LTS_OFF_CTRL, 32'h2);
        chk("disarmed", armed, 32'h0);
        give_verdict();
    end
endmodule : tb
